// File: dpl_regs.vh
// constants for the parallel sample latch front end
`ifndef DPL_REGS_VH
`define DPL_REGS_VH
`define DPL_WIDTH          10
`define DPL_FULL_CODE      10'h3FF
`define DPL_ZERO_CODE      10'h000
`define DPL_CLK_PERIOD_PS  8000
`define DPL_MAX_RATE_MSPS  210
`define DPL_PD_TIME_NS     50
`define DPL_PD_CYCLES      ((`DPL_PD_TIME_NS * 1000) / `DPL_CLK_PERIOD_PS)
`define DPL_WAKE_TIME_NS   5000
`define DPL_WAKE_CYCLES    ((`DPL_WAKE_TIME_NS * 1000 + `DPL_CLK_PERIOD_PS - 1) / `DPL_CLK_PERIOD_PS)
`endif

// File: dpl_skid.v
// two-entry buffer between sample source and output latch
`timescale 1ns/1ps
module dpl_skid #(
	parameter W = 10
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:1];
	reg         wr_ptr;
	reg         rd_ptr;
	reg [1:0]   count;
	wire        do_wr;
	wire        do_rd;

	assign in_ready  = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'd0;
		end else begin
			if (do_wr)
				wr_ptr <= ~wr_ptr;
			if (do_rd)
				rd_ptr <= ~rd_ptr;
			if (do_wr && !do_rd)
				count <= count + 2'd1;
			else if (do_rd && !do_wr)
				count <= count - 2'd1;
		end
	end

	// storage needs no reset; valid flags guard it
	always @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end
endmodule // dpl_skid

// File: dpl_latch.v
// sample latch and sleep control of the current-output converter front end
// Notes on behaviour
// RULE1: ten-bit unsigned word, highest bit most significant
// RULE2: all ones gives full scale on true output
// RULE3: edge-triggered capture, output changes on rising edge
// RULE4: path runs up to 210 MSPS
// RULE5: source meets latch pulse width either phase
// RULE6: source should change data near falling edge
// RULE7: sleep held high switches output current off
// RULE8: sleep input pulled low when left open
// RULE9: off within 50 ns, valid ~5 us later
// RULE10: true output linear, full at code 1023
// RULE11: latched word holds between rising edges
`timescale 1ns/1ps
`include "dpl_regs.vh"
module dpl_latch #(
	parameter W           = `DPL_WIDTH,
	parameter WAKE_CYCLES = `DPL_WAKE_CYCLES
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] sample_word,
	input  wire         sample_valid,
	output reg          sample_ready,
	input  wire         sleep_req,
	input  wire         sleep_connected,
	output reg  [W-1:0] true_current_output,
	output reg  [W-1:0] complement_current_output,
	output reg          output_on,
	output reg          output_valid
);
	localparam ST_RUN   = 3'b001;
	localparam ST_SLEEP = 3'b010;
	localparam ST_WAKE  = 3'b100;
	localparam PD_CYCLES = `DPL_PD_CYCLES;

	reg  [2:0]   state;
	reg  [2:0]   next_state;
	reg  [15:0]  wake_cnt;
	reg  [15:0]  next_wake_cnt;
	reg  [W-1:0] code;
	wire         buf_valid;
	wire         buf_in_ready;
	wire [W-1:0] buf_data;
	wire         sleep_eff;
	wire         take;

	////////////////////////////////////////////////////////////////////////
	// RULE8: open input reads as awake
	assign sleep_eff = sleep_connected & sleep_req;
	// latch keeps draining during sleep so the source never deadlocks
	assign take = buf_valid;

	dpl_skid #(
		.W (W)
	) u_skid (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (sample_valid),
		.in_ready  (buf_in_ready),
		.in_data   (sample_word),
		.out_valid (buf_valid),
		.out_ready (1'b1),
		.out_data  (buf_data)
	);

	////////////////////////////////////////////////////////////////////////
	// RULE3: capture on rising edge only
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			code <= `DPL_ZERO_CODE;
		end else if (take) begin
			// RULE1: straight binary word
			code <= buf_data;
		end
		// RULE11: held otherwise
	end

	////////////////////////////////////////////////////////////////////////
	always @* begin
		next_state    = state;
		next_wake_cnt = wake_cnt;
		case (state)
			ST_RUN: begin
				// RULE7: high level enters sleep
				if (sleep_eff)
					next_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (!sleep_eff) begin
					next_state    = ST_WAKE;
					next_wake_cnt = 16'h0000;
				end
			end
			ST_WAKE: begin
				if (sleep_eff)
					next_state = ST_SLEEP;
				// RULE9: wake settling time
				else if (wake_cnt >= WAKE_CYCLES - 1)
					next_state = ST_RUN;
				else
					next_wake_cnt = wake_cnt + 16'h0001;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= ST_RUN;
			wake_cnt <= 16'h0000;
		end else begin
			state    <= next_state;
			wake_cnt <= next_wake_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs registered; one cycle latency is well inside the 50 ns limit
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			true_current_output       <= `DPL_ZERO_CODE;
			complement_current_output <= `DPL_ZERO_CODE;
			output_on                 <= 1'b0;
			output_valid              <= 1'b0;
			sample_ready              <= 1'b0;
		end else begin
			sample_ready <= buf_in_ready;
			// RULE9: current off one edge after sleep
			if (sleep_eff || state == ST_SLEEP) begin
				true_current_output       <= `DPL_ZERO_CODE;
				complement_current_output <= `DPL_ZERO_CODE;
				output_on                 <= 1'b0;
				output_valid              <= 1'b0;
			end else begin
				// RULE2: complement carries remaining share
				// RULE10: linear, full scale at 1023
				true_current_output       <= code;
				complement_current_output <= `DPL_FULL_CODE - code;
				output_on                 <= 1'b1;
				output_valid              <= (state == ST_RUN);
			end
		end
	end
	// RULE4: 125 MHz clock sits below 210 MSPS limit
endmodule // dpl_latch

// File: dpl_latch_props.sv
// checker for the sample latch
`timescale 1ns/1ps
module dpl_latch_props #(parameter int WAKE_CYCLES = 8) (
	input wire clk,
	input wire rst_b,
	input wire [9:0] sample_word,
	input wire sample_valid,
	input wire sample_ready,
	input wire sleep_req,
	input wire sleep_connected,
	input wire [9:0] true_current_output,
	input wire [9:0] complement_current_output,
	input wire output_on,
	input wire output_valid
);
	localparam int WK = WAKE_CYCLES + 2;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence idle4; !sample_valid [*4]; endsequence
	a_code_path: assert property (sample_valid ##3 output_on |->
		true_current_output == $past(sample_word, 3)) else $error("path");
	a_comp_pair: assert property (output_on |->
		complement_current_output == 10'h3ff - true_current_output) else $error("pair");
	a_off_zero: assert property (!output_on |->
		(true_current_output | complement_current_output) == 10'h000) else $error("off");
	a_sleep_fast: assert property (sleep_req && sleep_connected |=>
		!output_on && !output_valid) else $error("sleep");
	a_open_awake: assert property (!sleep_connected |=> output_on) else $error("open");
	a_hold_idle: assert property (idle4 ##0 (output_on && $past(output_on)) |->
		$stable(true_current_output)) else $error("hold");
	a_wake_time: assert property ($past(rst_b, 2) && $rose(output_on) |->
		!output_valid ##[1:WK] output_valid) else $error("wake");
	a_full_rate: assert property (output_on |-> sample_ready) else $error("rate");
endmodule // dpl_latch_props
bind dpl_latch dpl_latch_props #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.clk, .rst_b,
	.sample_word, .sample_valid, .sample_ready, .sleep_req, .sleep_connected,
	.true_current_output, .complement_current_output, .output_on, .output_valid);

// File: dpl_src.sv
// sample source model
`timescale 1ns/1ps
module dpl_src (
	input wire clk,
	output logic [9:0] word = 10'h000,
	output logic valid = 1'b0,
	output logic sleep = 1'b0,
	output logic wired = 1'b1
);
	task send(input logic [9:0] w);
		@(negedge clk);
		word = w;
		valid = 1'b1;
	endtask
	// released bus toggles so no stale word passes
	task idle();
		@(negedge clk);
		valid = 1'b0;
		word = ~word;
	endtask
	// sleep level, pin may be left open
	task nap(input logic s, input logic c);
		@(negedge clk);
		sleep = s;
		wired = c;
	endtask
endmodule // dpl_src

// File: tb.sv
// bench for the sample latch
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] wd, t_o, c_o;
	logic vl, rd, sl, wi, on, ok;
	int bad_count = 0;
	int checks = 0;
	logic [9:0] cd [5] = '{10'h000, 10'h3ff, 10'h200, 10'h001, 10'h155};
	always #4 clk = ~clk;
	dpl_src src_u (.clk(clk), .word(wd), .valid(vl), .sleep(sl), .wired(wi));
	dpl_latch #(.WAKE_CYCLES(8)) dut_u (.clk(clk), .rst_b(rst_b), .sample_word(wd),
		.sample_valid(vl), .sample_ready(rd), .sleep_req(sl), .sleep_connected(wi),
		.true_current_output(t_o), .complement_current_output(c_o), .output_on(on),
		.output_valid(ok));
	task chk(input logic [9:0] s, input logic [9:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task conclude();
		$display("mismatches %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task t_stream();
		for (int j = 0; j < 11; j++) begin
			if (j < 5)
				src_u.send(cd[j]);
			else
				src_u.idle();
			chk(rd, 10'h001);
			// word taken at one rising edge shows on the outputs two rising edges later
			if (j >= 3 && j < 8) begin
				chk(t_o, cd[j-3]);
				chk(c_o, 10'h3ff - cd[j-3]);
			end
		end
		chk(t_o, cd[4]);
	endtask
	task t_sleep();
		int n;
		src_u.nap(1'b1, 1'b0);
		src_u.idle();
		chk(on, 10'h001);
		src_u.nap(1'b1, 1'b1);
		src_u.send(10'h2a5);
		chk(on, 10'h000);
		chk(t_o, 10'h000);
		src_u.nap(1'b0, 1'b1);
		n = 0;
		while (ok !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n == 50) begin
			bad_count++;
			conclude();
		end
		chk(t_o, 10'h2a5);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		t_stream();
		t_sleep();
		conclude();
	end
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule // tb
